// ==== include/event_counter_pkg.sv ====
// event_counter_pkg: constants, register map and field layout for the event counter pair.
// assumes a single 20 MHz clock and a classic Wishbone slave with 32-bit data, low byte used.
package event_counter_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int COUNT_W = 8;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_UPPER_COUNT    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LOWER_COUNT    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK       = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_POWER_MODE     = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_UPPER_OVERFLOW = 7;
	localparam int BIT_LOWER_OVERFLOW = 6;
	localparam int BIT_IRQ_REQUEST    = 0;
	localparam int BIT_IRQ_ENABLE     = 0;
	localparam int BIT_LOW_POWER_HOLD = 0;
	localparam int BIT_MODULE_STANDBY = 1;
	localparam int LOW_CTRL_BITS      = 6;

	// ----------------------------------------------------------------
	// reset values and counter constants
	// ----------------------------------------------------------------
	localparam logic [7:0]         RST_CONTROL_STATUS = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_ZERO         = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_ALL_ONES     = 8'hff;
	localparam logic [COUNT_W-1:0] COUNT_ONE          = 8'h01;
	localparam int                 SYNC_STAGES        = 2;

	// control/status layout, msb first
	typedef struct packed {
		logic upper_overflow_flag;
		logic lower_overflow_flag;
		logic spare_bit;
		logic channel_split_select;
		logic upper_count_enable;
		logic lower_count_enable;
		logic upper_reset_release;
		logic lower_reset_release;
	} counter_control_status_type;

	// power mode controls
	typedef struct packed {
		logic module_standby;
		logic low_power_hold;
	} power_mode_type;

endpackage : event_counter_pkg

// ==== src/async_event_counter.sv ====
// async_event_counter: two 8-bit event counters, cascadable to 16 bits, with Wishbone registers.
// assumes event pins synchronous-safe via on-chip two-stage synchronisers; one clock, synchronous reset.
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps

module async_event_counter #(
	parameter int COUNT_W = event_counter_pkg::COUNT_W
) (
	// clock and reset
	input  wire logic                                   REF_CLK_IN,
	input  wire logic                                   RST_IN,
	// wishbone slave
	input  wire logic                                   WB_CYC_IN,
	input  wire logic                                   WB_STB_IN,
	input  wire logic                                   WB_WE_IN,
	input  wire logic [event_counter_pkg::ADDR_W-1:0]   WB_ADR_IN,
	input  wire logic [event_counter_pkg::DATA_W/8-1:0] WB_SEL_IN,
	input  wire logic [event_counter_pkg::DATA_W-1:0]   WB_DAT_IN,
	output logic      [event_counter_pkg::DATA_W-1:0]   WB_DAT_OUT,
	output logic                                        WB_ACK_OUT,
	// event pins
	input  wire logic                                   EVENT_IN_LOW_IN,
	input  wire logic                                   EVENT_IN_HIGH_IN,
	// interrupt
	output logic                                        IRQ_OUT
);
	import event_counter_pkg::*;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [COUNT_W-1:0] wrap_inc(input logic [COUNT_W-1:0] value);
		wrap_inc = COUNT_W'(value + COUNT_ONE);
	endfunction : wrap_inc

	function automatic logic rise(input logic now_level, input logic old_level);
		rise = now_level & ~old_level;
	endfunction : rise

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0]                 ev_meta_ff,      nxt_ev_meta;
	logic [1:0]                 ev_sync_ff,      nxt_ev_sync;
	logic [1:0]                 ev_prev_ff,      nxt_ev_prev;
	counter_control_status_type ctrl_ff,         nxt_ctrl;
	power_mode_type             power_ff,        nxt_power;
	logic [COUNT_W-1:0]         upper_count_ff,  nxt_upper_count;
	logic [COUNT_W-1:0]         lower_count_ff,  nxt_lower_count;
	logic                       arm_upper_ff,    nxt_arm_upper;
	logic                       arm_lower_ff,    nxt_arm_lower;
	logic                       irq_flag_ff,     nxt_irq_flag;
	logic                       irq_enable_ff,   nxt_irq_enable;
	logic                       irq_ff,          nxt_irq;
	logic                       ack_ff,          nxt_ack;
	logic [DATA_W-1:0]          rdata_ff,        nxt_rdata;

	// ----------------------------------------------------------------
	// combinational event decode
	// ----------------------------------------------------------------
	logic lower_edge;
	logic upper_edge;
	logic lower_tick;
	logic lower_wrap;
	logic upper_src;
	logic upper_tick;
	logic upper_wrap;
	logic set_upper_ovf;
	logic set_lower_ovf;
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic ctrl_wr;
	logic clr_upper;
	logic clr_lower;

	always_comb begin
		lower_edge = rise(ev_sync_ff[0], ev_prev_ff[0]);
		upper_edge = rise(ev_sync_ff[1], ev_prev_ff[1]);
		lower_tick = lower_edge & ctrl_ff.lower_count_enable & ctrl_ff.lower_reset_release
			& ~power_ff.module_standby;
		lower_wrap = lower_tick & (lower_count_ff == COUNT_ALL_ONES);
		upper_src  = ctrl_ff.channel_split_select ? upper_edge : lower_wrap;
		upper_tick = upper_src & ctrl_ff.upper_count_enable & ctrl_ff.upper_reset_release
			& ~power_ff.module_standby;
		upper_wrap = upper_tick & (upper_count_ff == COUNT_ALL_ONES);
		// flags stay untouched while held in low power
		set_upper_ovf = upper_wrap & ~power_ff.low_power_hold;
		set_lower_ovf = lower_wrap & ctrl_ff.channel_split_select
			& ~power_ff.low_power_hold;
		bus_req = WB_CYC_IN & WB_STB_IN & ~ack_ff;
		bus_wr  = bus_req & WB_WE_IN & WB_SEL_IN[0];
		bus_rd  = bus_req & ~WB_WE_IN;
		ctrl_wr = bus_wr & (WB_ADR_IN == OFS_CONTROL_STATUS)
			& ~power_ff.low_power_hold & ~power_ff.module_standby;
		clr_upper = ctrl_wr & ~WB_DAT_IN[BIT_UPPER_OVERFLOW] & arm_upper_ff;
		clr_lower = ctrl_wr & ~WB_DAT_IN[BIT_LOWER_OVERFLOW] & arm_lower_ff;
	end

	// ----------------------------------------------------------------
	// synchroniser and edge history
	// ----------------------------------------------------------------
	always_comb begin
		nxt_ev_meta = {EVENT_IN_HIGH_IN, EVENT_IN_LOW_IN};
		nxt_ev_sync = ev_meta_ff;
		nxt_ev_prev = ev_sync_ff;
	end

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	always_comb begin
		nxt_lower_count = lower_count_ff;
		nxt_upper_count = upper_count_ff;
		if (!ctrl_ff.lower_reset_release) begin
			nxt_lower_count = COUNT_ZERO;
		end else if (lower_tick) begin
			nxt_lower_count = wrap_inc(lower_count_ff);
		end
		if (!ctrl_ff.upper_reset_release) begin
			nxt_upper_count = COUNT_ZERO;
		end else if (upper_tick) begin
			nxt_upper_count = wrap_inc(upper_count_ff);
		end
	end

	// ----------------------------------------------------------------
	// control/status with read-then-clear flags
	// ----------------------------------------------------------------
	always_comb begin
		nxt_ctrl      = ctrl_ff;
		nxt_arm_upper = arm_upper_ff;
		nxt_arm_lower = arm_lower_ff;
		if (ctrl_wr) begin
			// flag bits above the control field are never written directly
			nxt_ctrl[LOW_CTRL_BITS-1:0] = WB_DAT_IN[LOW_CTRL_BITS-1:0];
		end
		if (clr_upper) begin
			nxt_ctrl.upper_overflow_flag = 1'b0;
			nxt_arm_upper                = 1'b0;
		end
		if (clr_lower) begin
			nxt_ctrl.lower_overflow_flag = 1'b0;
			nxt_arm_lower                = 1'b0;
		end
		if (bus_rd && WB_ADR_IN == OFS_CONTROL_STATUS) begin
			if (ctrl_ff.upper_overflow_flag) begin
				nxt_arm_upper = 1'b1;
			end
			if (ctrl_ff.lower_overflow_flag) begin
				nxt_arm_lower = 1'b1;
			end
		end
		// a new overflow beats a clear in the same cycle and needs a fresh read
		if (set_upper_ovf) begin
			nxt_ctrl.upper_overflow_flag = 1'b1;
			nxt_arm_upper                = 1'b0;
		end
		if (set_lower_ovf) begin
			nxt_ctrl.lower_overflow_flag = 1'b1;
			nxt_arm_lower                = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt and power mode
	// ----------------------------------------------------------------
	always_comb begin
		nxt_irq_flag   = irq_flag_ff;
		nxt_irq_enable = irq_enable_ff;
		nxt_power      = power_ff;
		if (bus_wr && WB_ADR_IN == OFS_IRQ_STATUS && WB_DAT_IN[BIT_IRQ_REQUEST]) begin
			nxt_irq_flag = 1'b0;
		end
		if (set_upper_ovf || set_lower_ovf) begin
			nxt_irq_flag = 1'b1;
		end
		if (bus_wr && WB_ADR_IN == OFS_IRQ_MASK) begin
			nxt_irq_enable = WB_DAT_IN[BIT_IRQ_ENABLE];
		end
		if (bus_wr && WB_ADR_IN == OFS_POWER_MODE) begin
			nxt_power.low_power_hold = WB_DAT_IN[BIT_LOW_POWER_HOLD];
			nxt_power.module_standby = WB_DAT_IN[BIT_MODULE_STANDBY];
		end
		nxt_irq = nxt_irq_flag & nxt_irq_enable;
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_ack   = bus_req;
		nxt_rdata = rdata_ff;
		if (bus_rd) begin
			nxt_rdata = '0;
			unique case (WB_ADR_IN)
				OFS_CONTROL_STATUS: nxt_rdata[7:0] = ctrl_ff;
				OFS_UPPER_COUNT:    nxt_rdata[COUNT_W-1:0] = upper_count_ff;
				OFS_LOWER_COUNT:    nxt_rdata[COUNT_W-1:0] = lower_count_ff;
				OFS_IRQ_STATUS:     nxt_rdata[BIT_IRQ_REQUEST] = irq_flag_ff;
				OFS_IRQ_MASK:       nxt_rdata[BIT_IRQ_ENABLE] = irq_enable_ff;
				OFS_POWER_MODE:     nxt_rdata[1:0] = power_ff;
				default:            nxt_rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			ev_meta_ff     <= 2'h0;
			ev_sync_ff     <= 2'h0;
			ev_prev_ff     <= 2'h0;
			ctrl_ff        <= RST_CONTROL_STATUS;
			power_ff       <= 2'h0;
			upper_count_ff <= COUNT_ZERO;
			lower_count_ff <= COUNT_ZERO;
			arm_upper_ff   <= 1'b0;
			arm_lower_ff   <= 1'b0;
			irq_flag_ff    <= 1'b0;
			irq_enable_ff  <= 1'b0;
			irq_ff         <= 1'b0;
			ack_ff         <= 1'b0;
			rdata_ff       <= '0;
		end else begin
			ev_meta_ff     <= nxt_ev_meta;
			ev_sync_ff     <= nxt_ev_sync;
			ev_prev_ff     <= nxt_ev_prev;
			ctrl_ff        <= nxt_ctrl;
			power_ff       <= nxt_power;
			upper_count_ff <= nxt_upper_count;
			lower_count_ff <= nxt_lower_count;
			arm_upper_ff   <= nxt_arm_upper;
			arm_lower_ff   <= nxt_arm_lower;
			irq_flag_ff    <= nxt_irq_flag;
			irq_enable_ff  <= nxt_irq_enable;
			irq_ff         <= nxt_irq;
			ack_ff         <= nxt_ack;
			rdata_ff       <= nxt_rdata;
		end
	end

	assign WB_ACK_OUT = ack_ff;
	assign WB_DAT_OUT = rdata_ff;
	assign IRQ_OUT    = irq_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);

	AST_RESET_CASCADED: assert property ($past(RST_IN) |-> !ctrl_ff.channel_split_select
		&& upper_count_ff == COUNT_ZERO && lower_count_ff == COUNT_ZERO)
		else $error("reset did not clear control and counters");
	AST_CASCADE_CARRY: assert property (!ctrl_ff.channel_split_select && upper_tick
		|-> lower_wrap)
		else $error("upper counter advanced without lower overflow in cascade");
	AST_WRAP_16: assert property (lower_wrap && upper_wrap && !ctrl_ff.channel_split_select
		&& !power_ff.low_power_hold |=> lower_count_ff == COUNT_ZERO && upper_count_ff == COUNT_ZERO
		&& ctrl_ff.upper_overflow_flag)
		else $error("16-bit wrap did not clear pair and set upper flag");
	AST_IRQ_OUT: assert property ((set_upper_ovf || set_lower_ovf) && irq_enable_ff
		&& !(bus_wr && WB_ADR_IN == OFS_IRQ_MASK) |=> irq_flag_ff ##0 IRQ_OUT)
		else $error("overflow did not raise interrupt");
	AST_SPLIT_UPPER: assert property (ctrl_ff.channel_split_select && upper_edge
		&& ctrl_ff.upper_count_enable && ctrl_ff.upper_reset_release && !power_ff.module_standby
		|=> upper_count_ff == wrap_inc($past(upper_count_ff)))
		else $error("split upper counter missed high pin event");
	AST_SPLIT_LOWER_WRAP: assert property (set_lower_ovf
		|=> ctrl_ff.lower_overflow_flag && lower_count_ff == COUNT_ZERO)
		else $error("split lower wrap did not set lower flag");
	AST_LOW_POWER_FLAGS: assert property (power_ff.low_power_hold && !ctrl_ff.upper_overflow_flag
		&& !ctrl_ff.lower_overflow_flag |=> !ctrl_ff.upper_overflow_flag && !ctrl_ff.lower_overflow_flag)
		else $error("overflow flag set while held in low power");
	AST_ENABLE_HOLD: assert property (!ctrl_ff.lower_count_enable && ctrl_ff.lower_reset_release
		|=> $stable(lower_count_ff))
		else $error("lower counter moved while disabled");
	AST_RELEASE_ZERO: assert property (!ctrl_ff.upper_reset_release
		|=> upper_count_ff == COUNT_ZERO)
		else $error("upper counter not held at zero");
	AST_FLAG_NO_SW_SET: assert property (!ctrl_ff.upper_overflow_flag && !set_upper_ovf
		|=> !ctrl_ff.upper_overflow_flag)
		else $error("upper flag set without overflow");
	AST_STANDBY_HALT: assert property (power_ff.module_standby
		|=> $stable(upper_count_ff) && $stable(lower_count_ff) && $stable(ctrl_ff[5:0]))
		else $error("counters or control moved in module standby");
	AST_SYNC_LATENCY: assert property ($rose(EVENT_IN_LOW_IN) ##1 EVENT_IN_LOW_IN
		|-> ##1 lower_edge)
		else $error("low pin event not seen two cycles later");

endmodule : async_event_counter

// ==== test/event_source_model.sv ====
// event_source_model: drives the two event pins with bursts of rising edges.
// assumes one clock; each event is 2 clocks high then 2 clocks low, pins idle low.
`timescale 1ns/1ps

module event_source_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// burst request
	input  wire logic       start_in,
	input  wire logic [9:0] low_n_in,
	input  wire logic [9:0] high_n_in,
	output logic            busy_out,
	// event pins
	output logic            ev_low_out,
	output logic            ev_high_out
);
	logic [9:0] rem_low_ff;
	logic [9:0] rem_high_ff;
	logic [1:0] phase_ff;

	assign busy_out    = (rem_low_ff != 10'h000) || (rem_high_ff != 10'h000);
	assign ev_low_out  = (rem_low_ff != 10'h000) && (phase_ff < 2'h2);
	assign ev_high_out = (rem_high_ff != 10'h000) && (phase_ff < 2'h2);

	always @(posedge clk_in) begin
		if (rst_in) begin
			rem_low_ff  <= 10'h000;
			rem_high_ff <= 10'h000;
			phase_ff    <= 2'h0;
		end else if (start_in) begin
			rem_low_ff  <= low_n_in;
			rem_high_ff <= high_n_in;
			phase_ff    <= 2'h0;
		end else if (busy_out) begin
			phase_ff <= phase_ff + 2'h1;
			if (phase_ff == 2'h3 && rem_low_ff != 10'h000) rem_low_ff <= rem_low_ff - 10'h001;
			if (phase_ff == 2'h3 && rem_high_ff != 10'h000) rem_high_ff <= rem_high_ff - 10'h001;
		end
	end
endmodule : event_source_model

// ==== test/testbench.sv ====
// testbench: directed scenarios for the event counter pair over Wishbone.
// assumes the event source model on both pins and a 20 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("BAD %0t got %h expected %h", $time, (got), (exp)); end end

module testbench;
	import event_counter_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, irq, ev_lo, ev_hi, busy;
	logic        start = 1'b0;
	logic [9:0]  nlo = 10'h000, nhi = 10'h000;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	always #25 clk = ~clk;

	async_event_counter dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .EVENT_IN_LOW_IN(ev_lo), .EVENT_IN_HIGH_IN(ev_hi), .IRQ_OUT(irq));

	event_source_model src_u (.clk_in(clk), .rst_in(rst), .start_in(start), .low_n_in(nlo),
		.high_n_in(nhi), .busy_out(busy), .ev_low_out(ev_lo), .ev_high_out(ev_hi));

	// ----------------------------------------------------------------
	// bus and pin tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		int i;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'h1;
		wdat <= {24'h0, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : wb_cycle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		wb_cycle(1'b0, a, 8'h00, q);
		`CHK(q, {24'h0, exp})
	endtask : rd

	task automatic fire(input logic [9:0] l, input logic [9:0] h);
		int i;
		@(posedge clk);
		start <= 1'b1;
		nlo   <= l;
		nhi   <= h;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 5000 && busy; i++) @(posedge clk);
		if (i == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
		repeat (6) @(posedge clk);
	endtask : fire

	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge clk);
		`CHK(irq, exp)
	endtask : irq_chk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_reset();
		rd(OFS_CONTROL_STATUS, 8'h00);
		rd(OFS_UPPER_COUNT, 8'h00);
		rd(OFS_LOWER_COUNT, 8'h00);
		rd(8'h20, 8'h00);
		irq_chk(1'b0);
	endtask : sc_reset

	task automatic sc_gating();
		wr(OFS_CONTROL_STATUS, 8'h1c);
		fire(10'd3, 10'd3);
		rd(OFS_LOWER_COUNT, 8'h00);
		wr(OFS_CONTROL_STATUS, 8'h13);
		fire(10'd3, 10'd3);
		rd(OFS_LOWER_COUNT, 8'h00);
		rd(OFS_UPPER_COUNT, 8'h00);
	endtask : sc_gating

	task automatic sc_split_upper();
		wr(OFS_CONTROL_STATUS, 8'h10);
		wr(OFS_CONTROL_STATUS, 8'h1f);
		fire(10'd3, 10'd256);
		wr(OFS_CONTROL_STATUS, 8'h13);
		rd(OFS_CONTROL_STATUS, 8'h93);
		rd(OFS_UPPER_COUNT, 8'h00);
		rd(OFS_LOWER_COUNT, 8'h03);
		rd(OFS_IRQ_STATUS, 8'h01);
		irq_chk(1'b0);
		wr(OFS_IRQ_MASK, 8'h01);
		irq_chk(1'b1);
		wr(OFS_IRQ_STATUS, 8'h01);
		irq_chk(1'b0);
		wr(OFS_CONTROL_STATUS, 8'h13);
		rd(OFS_CONTROL_STATUS, 8'h13);
		wr(OFS_CONTROL_STATUS, 8'hd3);
		rd(OFS_CONTROL_STATUS, 8'h13);
	endtask : sc_split_upper

	task automatic sc_split_lower();
		wr(OFS_CONTROL_STATUS, 8'h10);
		rd(OFS_LOWER_COUNT, 8'h00);
		wr(OFS_CONTROL_STATUS, 8'h1f);
		fire(10'd256, 10'd0);
		irq_chk(1'b1);
		wr(OFS_CONTROL_STATUS, 8'h13);
		rd(OFS_CONTROL_STATUS, 8'h53);
		rd(OFS_LOWER_COUNT, 8'h00);
		wr(OFS_CONTROL_STATUS, 8'h13);
		rd(OFS_CONTROL_STATUS, 8'h13);
		wr(OFS_IRQ_STATUS, 8'h01);
		irq_chk(1'b0);
	endtask : sc_split_lower

	task automatic sc_cascade();
		wr(OFS_CONTROL_STATUS, 8'h00);
		wr(OFS_CONTROL_STATUS, 8'h0f);
		fire(10'd257, 10'd5);
		wr(OFS_CONTROL_STATUS, 8'h0b);
		rd(OFS_UPPER_COUNT, 8'h01);
		rd(OFS_LOWER_COUNT, 8'h01);
		rd(OFS_CONTROL_STATUS, 8'h0b);
		rd(OFS_IRQ_STATUS, 8'h00);
	endtask : sc_cascade

	task automatic sc_power();
		wr(OFS_CONTROL_STATUS, 8'h10);
		wr(OFS_CONTROL_STATUS, 8'h1f);
		wr(OFS_POWER_MODE, 8'h01);
		wr(OFS_CONTROL_STATUS, 8'h10);
		fire(10'd258, 10'd0);
		rd(OFS_LOWER_COUNT, 8'h02);
		rd(OFS_CONTROL_STATUS, 8'h1f);
		rd(OFS_IRQ_STATUS, 8'h00);
		wr(OFS_POWER_MODE, 8'h02);
		fire(10'd4, 10'd4);
		wr(OFS_CONTROL_STATUS, 8'h10);
		rd(OFS_LOWER_COUNT, 8'h02);
		rd(OFS_CONTROL_STATUS, 8'h1f);
		wr(OFS_POWER_MODE, 8'h00);
		fire(10'd1, 10'd0);
		rd(OFS_LOWER_COUNT, 8'h03);
	endtask : sc_power

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		sc_reset();
		sc_gating();
		sc_split_upper();
		sc_split_lower();
		sc_cascade();
		sc_power();
		// mid-run reset with control 0x1f and a nonzero lower count
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		sc_reset();
		tally_and_finish();
	end
endmodule : testbench
